//--- verilog/flyback_prot.sv
`timescale 1ns/1ps
module flyback_prot #(
	parameter logic [31:0] HALF_PRESET = 32'(flyback_prot_pkg::HALF_PRESET_CYC),
	parameter logic [31:0] RESTART_WAIT = 32'(flyback_prot_pkg::RESTART_CYC),
	parameter logic [31:0] START_UNIT = 32'(flyback_prot_pkg::START_UNIT_CYC)
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic line_sync_pin,
	input wire flyback_prot_pkg::sense_t sense,
	input wire flyback_prot_pkg::mode_t mode,
	output logic gate_enable,
	output logic [15:0] vin_rms,
	output logic [15:0] ton_out,
	output logic [15:0] fb_filtered,
	output logic notch_active,
	output logic vin_protect_active
);
	flyback_prot_pkg::state_t s;
	flyback_prot_pkg::state_t n;
	logic sync_edge;
	logic period_tick;
	logic take;
	logic [31:0] period_len;
	logic [15:0] ocp2_lvl;
	logic [31:0] start_lim;
	logic [47:0] clamp_term;
	logic [31:0] cs_term;
	logic [31:0] cand;
	logic [4:0] phase_tri;
	logic [31:0] mod_up;
	logic [31:0] mod_dn;
	logic [31:0] ton_sum;
	logic [3:0] trig;
	logic latch_req;
	logic [31:0] rd_word;
	logic [31:0] ctrl;

	assign ctrl = s.cfg[flyback_prot_pkg::REG_CTRL];
	assign hrdata = s.hrdata;
	assign hreadyout = s.hreadyout;
	assign hresp = s.hresp;
	assign gate_enable = s.gate_en;
	assign vin_rms = s.vin_rms;
	assign ton_out = s.ton_out;
	assign fb_filtered = s.fb_filt;
	assign notch_active = s.notch_active;
	assign vin_protect_active = s.vin_prot_active;

	always_comb begin
		n = s;
		// Line sync pin, three stages, rising edge once stages two and three agree on a new high level
		n.sync_pipe = {s.sync_pipe[1:0], line_sync_pin};
		sync_edge = 1'b0;
		if (s.sync_pipe[1] == s.sync_pipe[2] && s.sync_pipe[2] != s.sync_lvl) begin
			n.sync_lvl = s.sync_pipe[2];
			sync_edge = s.sync_pipe[2];
		end
		n.meas_cnt = s.meas_cnt + 32'h0000_0001;
		if (sync_edge) begin
			n.meas_cnt = 32'h0000_0000;
			n.sync_len = s.meas_cnt;
			n.sync_ok = !mode.burst_power_save && s.meas_cnt >= (HALF_PRESET >> 1)
				&& s.meas_cnt < (HALF_PRESET << 1);
		end else if (mode.burst_power_save || s.meas_cnt >= (HALF_PRESET << 1)) begin
			n.sync_ok = 1'b0;
		end
		period_len = s.sync_ok ? s.sync_len : HALF_PRESET;
		period_tick = s.sync_ok ? sync_edge : (s.period_cnt >= period_len - 32'h0000_0001);
		n.period_cnt = period_tick ? 32'h0000_0000 : s.period_cnt + 32'h0000_0001;

		// Input estimate from clamp current at end of on-time
		take = sense.on_end && s.sample_cnt >= (period_len >> flyback_prot_pkg::SAMPLE_SHIFT);
		clamp_term = 48'(s.cfg[flyback_prot_pkg::REG_WINDING][15:0])
			* 48'(32'(sense.clamp_current_sample - s.cfg[flyback_prot_pkg::REG_CLAMP][15:0])
			* 32'(s.cfg[flyback_prot_pkg::REG_WINDING][31:16])
			- 32'(s.cfg[flyback_prot_pkg::REG_CLAMP][31:16]));
		cs_term = (32'(s.cfg[flyback_prot_pkg::REG_RIN][15:0]) * 32'(sense.cs_peak)) >> 8;
		cand = 32'(clamp_term >> 8) + cs_term;
		if (s.sample_cnt != 32'hFFFF_FFFF) begin
			n.sample_cnt = s.sample_cnt + 32'h0000_0001;
		end
		if (take) begin
			n.sample_cnt = 32'h0000_0000;
			n.sample_idx = s.sample_idx + 6'h01;
			n.fb_acc = s.fb_acc + 32'(sense.fb);
			if (cand > s.peak_acc) begin
				n.peak_acc = cand;
			end
		end
		if (period_tick) begin
			n.vin_peak = (n.peak_acc > 32'h0000_FFFF) ? 16'hFFFF : n.peak_acc[15:0];
			n.vin_rms = 16'((32'(n.vin_peak) * flyback_prot_pkg::RMS_FACTOR) >> 8);
			n.peak_acc = 32'h0000_0000;
			n.sample_idx = 6'h00;
			n.fb_avg = 16'(n.fb_acc >> flyback_prot_pkg::SAMPLE_SHIFT);
			n.fb_acc = 32'h0000_0000;
		end
		n.vin_prot_active = !mode.burst_power_save
			|| ctrl[flyback_prot_pkg::CTRL_BURST_INPUT_PROTECT];

		// Notch: half-period mean removes double-line ripple
		if ((mode.valley_one_quasi_resonant || mode.discontinuous_conduction) && s.sync_ok) begin
			if (period_tick && s.notch_cnt != 8'hFF) begin
				n.notch_cnt = s.notch_cnt + 8'h01;
			end
		end else begin
			n.notch_cnt = 8'h00;
		end
		n.notch_active = (mode.valley_one_quasi_resonant || mode.discontinuous_conduction)
			&& n.sync_ok && n.notch_cnt >= s.cfg[flyback_prot_pkg::REG_PFC][23:16];
		if (s.notch_active) begin
			n.fb_filt = 16'(32'(s.fb_avg)
				+ (32'(sense.fb - s.fb_avg) >> s.cfg[flyback_prot_pkg::REG_PFC][11:8]));
		end else begin
			n.fb_filt = sense.fb;
		end
		if (period_tick) begin
			n.fb_stable = ((s.fb_filt > s.fb_ref) ? (s.fb_filt - s.fb_ref)
				: (s.fb_ref - s.fb_filt)) < flyback_prot_pkg::FB_STABLE_TOL;
			n.fb_ref = s.fb_filt;
		end

		// Enhanced correction of mapped on-time
		phase_tri = s.sample_idx[5] ? ~s.sample_idx[4:0] : s.sample_idx[4:0];
		mod_up = (32'(s.cfg[flyback_prot_pkg::REG_PFC][7:0]) * 32'(phase_tri)
			* 32'(s.vin_rms)) >> 12;
		mod_dn = (32'(s.cfg[flyback_prot_pkg::REG_PFC][7:0])
			* ((32'(sense.vout) * 32'(sense.iout)) >> 16)) >> 4;
		ton_sum = 32'(sense.ton_map) + mod_up;
		ton_sum = (ton_sum > mod_dn) ? ton_sum - mod_dn : 32'h0000_0000;
		if (s.cfg[flyback_prot_pkg::REG_PFC][7:0] != 8'h00 && s.fb_stable
			&& (mode.valley_one_quasi_resonant || mode.discontinuous_conduction)) begin
			n.ton_out = (ton_sum > 32'h0000_FFFF) ? 16'hFFFF : ton_sum[15:0];
		end else begin
			n.ton_out = sense.ton_map;
		end

		// Protections
		ocp2_lvl = flyback_prot_pkg::OCP2_L3;
		if (flyback_prot_pkg::OCP2_L0 > s.cfg[flyback_prot_pkg::REG_OCP][15:0]) begin
			ocp2_lvl = flyback_prot_pkg::OCP2_L0;
		end else if (flyback_prot_pkg::OCP2_L1 > s.cfg[flyback_prot_pkg::REG_OCP][15:0]) begin
			ocp2_lvl = flyback_prot_pkg::OCP2_L1;
		end else if (flyback_prot_pkg::OCP2_L2 > s.cfg[flyback_prot_pkg::REG_OCP][15:0]) begin
			ocp2_lvl = flyback_prot_pkg::OCP2_L2;
		end
		start_lim = 32'(48'(s.cfg[flyback_prot_pkg::REG_START][31:16]) * 48'(START_UNIT));
		trig = 4'h0;
		n.ocp_cnt = 16'h0000;
		n.uv_cnt = 16'h0000;
		n.ov_cnt = 32'h0000_0000;
		n.start_cnt = 32'h0000_0000;
		if (s.pst == flyback_prot_pkg::P_RUN) begin
			if (sense.cs_now > ocp2_lvl) begin
				n.ocp_cnt = s.ocp_cnt + 16'h0001;
				trig[flyback_prot_pkg::F_OCP] = s.ocp_cnt >= s.cfg[flyback_prot_pkg::REG_OCP][31:16];
			end
			if (!mode.startup && !mode.burst_power_save && ctrl[flyback_prot_pkg::CTRL_UV_ENABLE]
				&& sense.vout < s.cfg[flyback_prot_pkg::REG_UV][15:0]) begin
				n.uv_cnt = s.uv_cnt + 16'h0001;
				trig[flyback_prot_pkg::F_UV] = s.uv_cnt >= s.cfg[flyback_prot_pkg::REG_UV][31:16];
			end
			if (mode.startup) begin
				n.start_cnt = s.start_cnt + 32'h0000_0001;
				trig[flyback_prot_pkg::F_UV_START] = s.start_cnt >= start_lim
					&& sense.vout < s.cfg[flyback_prot_pkg::REG_START][15:0];
			end
			if (!mode.burst_power_save && sense.vout > s.cfg[flyback_prot_pkg::REG_OV][15:0]) begin
				n.ov_cnt = s.ov_cnt + 32'h0000_0001;
				trig[flyback_prot_pkg::F_OV] = s.ov_cnt >= (period_len >> flyback_prot_pkg::OV_BLANK_SHIFT);
			end
		end
		latch_req = (trig[flyback_prot_pkg::F_UV] && ctrl[flyback_prot_pkg::CTRL_UV_LATCH])
			|| (trig[flyback_prot_pkg::F_OV] && ctrl[flyback_prot_pkg::CTRL_OV_LATCH]);
		n.wait_cnt = 32'h0000_0000;
		case (s.pst)
			flyback_prot_pkg::P_RUN: begin
				if (trig != 4'h0) begin
					n.fault = s.fault | trig;
					n.gate_en = 1'b0;
					n.pst = latch_req ? flyback_prot_pkg::P_LATCH : flyback_prot_pkg::P_WAIT;
				end
			end
			flyback_prot_pkg::P_WAIT: begin
				n.wait_cnt = s.wait_cnt + 32'h0000_0001;
				if (s.wait_cnt >= RESTART_WAIT - 32'h0000_0001) begin
					n.pst = flyback_prot_pkg::P_RUN;
					n.gate_en = 1'b1;
				end
			end
			flyback_prot_pkg::P_LATCH: begin
				n.gate_en = 1'b0;
			end
			default: begin
				n.pst = flyback_prot_pkg::P_LATCH;
				n.gate_en = 1'b0;
			end
		endcase

		// AHB-Lite slave, zero wait states
		if (s.ahb_wr && s.ahb_idx < 4'(flyback_prot_pkg::NCFG)) begin
			n.cfg[s.ahb_idx] = hwdata;
		end
		n.ahb_wr = 1'b0;
		rd_word = 32'h0000_0000;
		case (haddr[5:2])
			flyback_prot_pkg::REG_STATUS: begin
				rd_word[flyback_prot_pkg::ST_FAULT_LO +: 4] = s.fault;
				rd_word[flyback_prot_pkg::ST_LATCHED] = s.pst == flyback_prot_pkg::P_LATCH;
				rd_word[flyback_prot_pkg::ST_GATE] = s.gate_en;
				rd_word[flyback_prot_pkg::ST_SYNC] = s.sync_ok;
				rd_word[flyback_prot_pkg::ST_NOTCH] = s.notch_active;
			end
			flyback_prot_pkg::REG_VIN: begin
				rd_word = {s.vin_peak, s.vin_rms};
			end
			default: begin
				if (haddr[5:2] < 4'(flyback_prot_pkg::NCFG)) begin
					rd_word = (s.ahb_wr && s.ahb_idx == haddr[5:2]) ? hwdata : s.cfg[haddr[5:2]];
				end
			end
		endcase
		if (haddr[31:6] != 26'h0000000) begin
			rd_word = 32'h0000_0000;
		end
		if (hsel && htrans[1] && hready) begin
			n.ahb_wr = hwrite && haddr[31:6] == 26'h0000000;
			n.ahb_idx = haddr[5:2];
			n.hrdata = hwrite ? 32'h0000_0000 : rd_word;
		end
		n.hreadyout = 1'b1;
		n.hresp = 1'b0;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
			s.cfg <= {flyback_prot_pkg::NCFG{flyback_prot_pkg::CFG_RESET}};
			s.pst <= flyback_prot_pkg::P_RUN;
			s.gate_en <= 1'b1;
			s.vin_prot_active <= 1'b1;
			s.hreadyout <= 1'b1;
		end else begin
			s <= n;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	AST_SAMPLE: assert property (s.sample_idx != $past(s.sample_idx) && !$past(period_tick)
		|-> $past(sense.on_end)) else $error("sample taken without on-time end");
	AST_RMS: assert property (period_tick |=> s.vin_rms
		== 16'((32'(s.vin_peak) * 32'h0000_00B5) >> 8)) else $error("rms not 0.707 of peak");
	AST_RMS_HOLD: assert property (!period_tick |=> $stable(s.vin_rms))
		else $error("rms changed mid half period");
	AST_VINPROT: assert property (mode.burst_power_save
		&& !ctrl[flyback_prot_pkg::CTRL_BURST_INPUT_PROTECT] |=> !vin_protect_active)
		else $error("input protection active in burst");
	AST_NOTCH: assert property (notch_active |-> s.sync_ok)
		else $error("notch active without line sync");
	AST_ENHANCED_FACTOR_CORRECTION_OFF: assert property (s.cfg[flyback_prot_pkg::REG_PFC][7:0] == 8'h00
		|=> ton_out == $past(sense.ton_map)) else $error("on-time modulated at zero gain");
	AST_OCP: assert property (s.pst == flyback_prot_pkg::P_RUN && sense.cs_now > ocp2_lvl
		&& s.ocp_cnt >= s.cfg[flyback_prot_pkg::REG_OCP][31:16]
		|=> !gate_enable && s.fault[flyback_prot_pkg::F_OCP]) else $error("overcurrent missed");
	AST_OCP2: assert property (ocp2_lvl > s.cfg[flyback_prot_pkg::REG_OCP][15:0]
		|| ocp2_lvl == 16'h0640) else $error("second level not above limit");
	AST_UV_BURST: assert property (mode.burst_power_save |=> s.uv_cnt == 16'h0000)
		else $error("undervoltage counted in burst");
	AST_OV_BURST: assert property (mode.burst_power_save |=> s.ov_cnt == 32'h0000_0000)
		else $error("overvoltage counted in burst");
	AST_OV_BLANK: assert property (s.pst == flyback_prot_pkg::P_RUN
		|-> s.ov_cnt <= (period_len >> 2) + 32'h0000_0001) else $error("ov blank overrun");
	AST_LATCH: assert property (s.pst == flyback_prot_pkg::P_LATCH
		|=> s.pst == flyback_prot_pkg::P_LATCH && !gate_enable) else $error("latch released");
endmodule // flyback_prot

//--- verilog/flyback_prot_pkg.sv
package flyback_prot_pkg;
	// Timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int HALF_PRESET_NS = 9823000;
	localparam int HALF_PRESET_CYC = HALF_PRESET_NS / CLK_PERIOD_NS;
	localparam int SAMPLE_SHIFT = 6;
	localparam int OV_BLANK_SHIFT = 2;
	localparam int START_SCALE = 967;
	localparam int CVCC_UNIT_NF = 100;
	localparam int START_UNIT_CYC = START_SCALE * CVCC_UNIT_NF / CLK_PERIOD_NS;
	localparam int RESTART_NS = 1000000000;
	localparam int RESTART_CYC = RESTART_NS / CLK_PERIOD_NS;
	localparam logic [31:0] RMS_FACTOR = 32'h0000_00B5;
	localparam logic [15:0] FB_STABLE_TOL = 16'h0040;
	// Second overcurrent options, millivolts
	localparam logic [15:0] OCP2_L0 = 16'h0258;
	localparam logic [15:0] OCP2_L1 = 16'h0320;
	localparam logic [15:0] OCP2_L2 = 16'h04B0;
	localparam logic [15:0] OCP2_L3 = 16'h0640;
	// Register word indices (byte address = 4 * index)
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_WINDING = 4'h1;
	localparam logic [3:0] REG_CLAMP = 4'h2;
	localparam logic [3:0] REG_RIN = 4'h3;
	localparam logic [3:0] REG_OCP = 4'h4;
	localparam logic [3:0] REG_UV = 4'h5;
	localparam logic [3:0] REG_START = 4'h6;
	localparam logic [3:0] REG_OV = 4'h7;
	localparam logic [3:0] REG_PFC = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'h9;
	localparam logic [3:0] REG_VIN = 4'hA;
	localparam int NCFG = 9;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	// CTRL bits
	localparam int CTRL_BURST_INPUT_PROTECT = 0;
	localparam int CTRL_UV_ENABLE = 1;
	localparam int CTRL_UV_LATCH = 2;
	localparam int CTRL_OV_LATCH = 3;
	// STATUS bits
	localparam int ST_FAULT_LO = 0;
	localparam int ST_LATCHED = 4;
	localparam int ST_GATE = 5;
	localparam int ST_SYNC = 6;
	localparam int ST_NOTCH = 7;
	// Fault vector bits
	localparam int F_OCP = 0;
	localparam int F_UV = 1;
	localparam int F_UV_START = 2;
	localparam int F_OV = 3;

	typedef struct packed {
		logic on_end;
		logic [15:0] clamp_current_sample;
		logic [15:0] cs_peak;
		logic [15:0] cs_now;
		logic [15:0] vout;
		logic [15:0] iout;
		logic [15:0] fb;
		logic [15:0] ton_map;
	} sense_t;

	typedef struct packed {
		logic burst_power_save;
		logic valley_one_quasi_resonant;
		logic discontinuous_conduction;
		logic startup;
	} mode_t;

	typedef enum logic [1:0] {P_RUN, P_WAIT, P_LATCH} prot_state_t;

	typedef struct packed {
		logic [2:0] sync_pipe;
		logic sync_lvl;
		logic sync_ok;
		logic [31:0] meas_cnt;
		logic [31:0] sync_len;
		logic [31:0] period_cnt;
		logic [31:0] sample_cnt;
		logic [5:0] sample_idx;
		logic [31:0] peak_acc;
		logic [15:0] vin_peak;
		logic [15:0] vin_rms;
		logic [7:0] notch_cnt;
		logic notch_active;
		logic [31:0] fb_acc;
		logic [15:0] fb_avg;
		logic [15:0] fb_filt;
		logic [15:0] fb_ref;
		logic fb_stable;
		logic [15:0] ton_out;
		logic [15:0] ocp_cnt;
		logic [15:0] uv_cnt;
		logic [31:0] start_cnt;
		logic [31:0] ov_cnt;
		logic [31:0] wait_cnt;
		prot_state_t pst;
		logic [3:0] fault;
		logic gate_en;
		logic vin_prot_active;
		logic [NCFG-1:0][31:0] cfg;
		logic ahb_wr;
		logic [3:0] ahb_idx;
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} state_t;
endpackage

//--- bench/power_stage_model.sv
`timescale 1ns/1ps
// Flyback stage seen through the sense pins; DC input, so the line never syncs
module power_stage_model (
	input wire logic ref_clk,
	input wire logic [15:0] cs_set,
	input wire logic [15:0] peak_set,
	input wire logic [15:0] vout_set,
	input wire logic [15:0] ton_set,
	output flyback_prot_pkg::sense_t sense,
	output logic line_sync_pin
);
	logic [3:0] phase_r;
	initial begin
		phase_r = 4'h0;
		sense = '0;
		line_sync_pin = 1'b0;
	end
	// On-time ends once every 16 cycles
	always @(posedge ref_clk) begin
		phase_r <= phase_r + 4'h1;
		sense.on_end <= (phase_r == 4'hF);
		sense.clamp_current_sample <= 16'h0000;
		sense.cs_peak <= peak_set;
		sense.cs_now <= cs_set;
		sense.vout <= vout_set;
		sense.iout <= 16'h0100;
		sense.fb <= 16'h0800;
		sense.ton_map <= ton_set;
		line_sync_pin <= 1'b0;
	end
endmodule // power_stage_model

//--- bench/flyback_vin_estimation_pfc_protection_test.sv
`timescale 1ns/1ps
module flyback_vin_estimation_pfc_protection_test;
	localparam logic [31:0] HP = 32'h0000_0280;
	localparam logic [31:0] RW = 32'h0000_0032;
	localparam logic [31:0] SU = 32'h0000_0004;
	logic ref_clk, resetn, hsel, hwrite, hready, line_sync_pin;
	logic hreadyout, hresp, gate_enable, notch_active, vin_protect_active;
	logic [31:0] haddr, hwdata, hrdata, d, seed, cycles;
	logic [1:0] htrans;
	logic [15:0] cs_set, peak_set, vout_set, ton_set, lvl, lim, vin_rms, ton_out, fb_filtered;
	flyback_prot_pkg::sense_t sense;
	flyback_prot_pkg::mode_t mode;
	int n_mismatch, checks_done, n;
	assign hready = hreadyout;

	flyback_prot #(.HALF_PRESET(HP), .RESTART_WAIT(RW), .START_UNIT(SU)) dut (
		.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .line_sync_pin(line_sync_pin), .sense(sense),
		.mode(mode), .gate_enable(gate_enable), .vin_rms(vin_rms), .ton_out(ton_out),
		.fb_filtered(fb_filtered), .notch_active(notch_active),
		.vin_protect_active(vin_protect_active));
	power_stage_model stage (.ref_clk(ref_clk), .cs_set(cs_set), .peak_set(peak_set),
		.vout_set(vout_set), .ton_set(ton_set), .sense(sense), .line_sync_pin(line_sync_pin));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction
	// Smallest option strictly above the low-line limit; the top option once the limit reaches it
	function automatic logic [15:0] ocp2(input logic [15:0] l);
		if (l < flyback_prot_pkg::OCP2_L0) return flyback_prot_pkg::OCP2_L0;
		if (l < flyback_prot_pkg::OCP2_L1) return flyback_prot_pkg::OCP2_L1;
		if (l < flyback_prot_pkg::OCP2_L2) return flyback_prot_pkg::OCP2_L2;
		return flyback_prot_pkg::OCP2_L3;
	endfunction
	function automatic logic [15:0] rms_of(input logic [15:0] p);
		return 16'((32'(p) * flyback_prot_pkg::RMS_FACTOR) >> 8);
	endfunction

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic ok, input string msg);
		checks_done++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk);
	endtask
	task automatic bus(input logic w, input logic [3:0] idx, input logic [31:0] wd);
		@(posedge ref_clk);
		hsel <= 1'b1;
		haddr <= {26'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge ref_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge ref_clk); while (hready !== 1'b1);
		d = hrdata;
	endtask
	task automatic wait_gate(input logic v, input int lim_cyc);
		n = 0;
		while (gate_enable !== v && n < lim_cyc) begin
			cyc(1);
			n++;
		end
	endtask
	task automatic rst;
		resetn <= 1'b0;
		cyc(16);
		resetn <= 1'b1;
		cyc(1);
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles <= cycles + 32'h1;
		if (cycles == 32'h0000_4E20) begin
			n_mismatch++;
			report_and_stop;
		end
	end

	initial begin
		n_mismatch = 0;
		checks_done = 0;
		cycles = 32'h0;
		seed = 32'h0000_C53B;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		{cs_set, peak_set, vout_set, ton_set} = '0;
		mode = '0;
		resetn = 1'b0;
		rst;
		chk(gate_enable === 1'b1 && vin_protect_active === 1'b1 && hresp === 1'b0, "reset outs");
		bus(1'b0, flyback_prot_pkg::REG_CTRL, 32'h0);
		chk(d === 32'h0, "ctrl reset");
		seed = xs(seed);
		bus(1'b1, flyback_prot_pkg::REG_UV, seed);
		bus(1'b0, flyback_prot_pkg::REG_UV, 32'h0);
		chk(d === seed, "uv readback");
		bus(1'b1, flyback_prot_pkg::REG_STATUS, 32'hFFFF_FFFF);
		bus(1'b0, flyback_prot_pkg::REG_STATUS, 32'h0);
		chk(d[3:0] === 4'h0, "status write ignored");
		bus(1'b0, 4'hF, 32'h0);
		chk(d === 32'h0, "unmapped read");
		$display("test registers done");
		for (int i = 0; i < 3; i++) begin
			rst;
			seed = xs(seed);
			lim = (i == 0) ? 16'h0320 : seed[15:0] % 16'h0640;
			lvl = ocp2(lim);
			bus(1'b1, flyback_prot_pkg::REG_OCP, {16'h0014, lim});
			cs_set <= lvl;
			cyc(40);
			chk(gate_enable === 1'b1, "ocp at level");
			cs_set <= lvl + 16'h1;
			cyc(18);
			chk(gate_enable === 1'b1, "ocp early");
			wait_gate(1'b0, 12);
			chk(n < 12, "ocp trip");
			bus(1'b0, flyback_prot_pkg::REG_STATUS, 32'h0);
			chk(d[0] === 1'b1 && d[4] === 1'b0, "ocp flag");
			cs_set <= 16'h0;
			cyc(int'(RW) - 14);
			chk(gate_enable === 1'b0, "ocp wait");
			wait_gate(1'b1, 20);
			chk(n < 20, "ocp restart");
		end
		$display("test overcurrent done");
		rst;
		mode.burst_power_save <= 1'b1;
		vout_set <= 16'h3000;
		bus(1'b1, flyback_prot_pkg::REG_CTRL, 32'h8);
		bus(1'b1, flyback_prot_pkg::REG_OV, 32'h0000_2000);
		cyc(300);
		chk(gate_enable === 1'b1, "ov in burst");
		mode.burst_power_save <= 1'b0;
		cyc(150);
		chk(gate_enable === 1'b1, "ov early");
		wait_gate(1'b0, 30);
		chk(n < 30, "ov trip");
		vout_set <= 16'h0;
		cyc(3 * int'(RW));
		chk(gate_enable === 1'b0, "ov latched");
		bus(1'b0, flyback_prot_pkg::REG_STATUS, 32'h0);
		chk(d[3] === 1'b1 && d[4] === 1'b1, "ov flags");
		$display("test overvoltage done");
		rst;
		mode.burst_power_save <= 1'b1;
		vout_set <= 16'h0800;
		bus(1'b1, flyback_prot_pkg::REG_CTRL, 32'h2);
		bus(1'b1, flyback_prot_pkg::REG_UV, {16'h0014, 16'h1000});
		cyc(60);
		chk(gate_enable === 1'b1, "uv in burst");
		mode.burst_power_save <= 1'b0;
		cyc(18);
		chk(gate_enable === 1'b1, "uv early");
		wait_gate(1'b0, 12);
		chk(n < 12, "uv trip");
		bus(1'b0, flyback_prot_pkg::REG_STATUS, 32'h0);
		chk(d[1] === 1'b1 && d[4] === 1'b0, "uv flags");
		wait_gate(1'b1, int'(RW) + 20);
		chk(n < int'(RW) + 20 && n > int'(RW) - 20, "uv restart");
		$display("test undervoltage done");
		mode.startup <= 1'b1;
		rst;
		bus(1'b1, flyback_prot_pkg::REG_START, {16'h000A, 16'h1000});
		chk(gate_enable === 1'b1, "startup early");
		wait_gate(1'b0, 10 * int'(SU) + 10);
		chk(n < 10 * int'(SU) + 10, "startup trip");
		bus(1'b0, flyback_prot_pkg::REG_STATUS, 32'h0);
		chk(d[2] === 1'b1 && d[4] === 1'b0, "startup flags");
		mode.startup <= 1'b0;
		$display("test startup done");
		rst;
		mode.burst_power_save <= 1'b1;
		cyc(3);
		chk(vin_protect_active === 1'b0, "burst no vin prot");
		bus(1'b1, flyback_prot_pkg::REG_CTRL, 32'h1);
		cyc(3);
		chk(vin_protect_active === 1'b1, "burst vin prot");
		mode.burst_power_save <= 1'b0;
		bus(1'b1, flyback_prot_pkg::REG_RIN, 32'h0000_0100);
		for (int i = 0; i < 2; i++) begin
			lvl = (i == 0) ? 16'h0400 : 16'h0200;
			peak_set <= lvl;
			cyc(3 * int'(HP));
			bus(1'b0, flyback_prot_pkg::REG_VIN, 32'h0);
			chk(d[31:16] === lvl && d[15:0] === rms_of(lvl), "vin estimate");
			chk(vin_rms === rms_of(lvl), "vin port");
		end
		seed = xs(seed);
		ton_set <= seed[15:0];
		bus(1'b1, flyback_prot_pkg::REG_PFC, 32'h0);
		cyc(4);
		chk(ton_out === seed[15:0], "ton pass");
		chk(notch_active === 1'b0, "notch idle");
		chk(fb_filtered === 16'h0800, "fb unfiltered without sync");
		mode.discontinuous_conduction <= 1'b1;
		peak_set <= 16'h0000;
		ton_set <= 16'h1000;
		bus(1'b1, flyback_prot_pkg::REG_PFC, 32'h0000_0010);
		cyc(3 * int'(HP));
		chk(ton_out !== 16'h1000, "ton modulated at nonzero gain");
		bus(1'b1, flyback_prot_pkg::REG_PFC, 32'h0);
		cyc(4);
		chk(ton_out === 16'h1000, "ton restored at zero gain");
		mode.discontinuous_conduction <= 1'b0;
		$display("test estimate done");
		report_and_stop;
	end
endmodule // flyback_vin_estimation_pfc_protection_test
